// [logic/pvip_params.svh]
// Constants of the parallel video input port
// Operation
// [RQ1] Sample on software-selected edge, rising after reset
// [RQ2] Source keeps sync, qualifier, bus stable
// [RQ3] Accept BT.656 stream with embedded sync codes
// [RQ4] BT.656 bytes taken from low bus byte
// [RQ5] Source keeps line rate within resolution limit
// [RQ6] Interlaced NTSC/PAL fields, landscape orientation only
// [RQ7] Source keeps line sync and porch widths
// [RQ8] Source keeps vertical sync and blanking lines
// [RQ9] Vertical sync line delay defaults five, max fifteen
// [RQ10] Pixels accepted only while qualifier high; BT.656 mode ignores the qualifier
`ifndef PVIP_PARAMS_SVH
`define PVIP_PARAMS_SVH
`define PVIP_PIX_W 24
`define PVIP_BT_W 8
`define PVIP_VSDLY_W 4
`define PVIP_VSDLY_RST 4'h5
`define PVIP_VSDLY_MAX 4'hf
`define PVIP_CODE_FF 8'hff
`define PVIP_CODE_00 8'h00
`define PVIP_BIT_F 6
`define PVIP_BIT_V 5
`define PVIP_BIT_H 4
`endif

// [logic/pvip_pkg.sv]
// Types of the parallel video input port
package pvip_pkg;
  // Timing reference code tracker, Gray coded along the code sequence
  typedef enum logic [1:0] {
    PVIP_TR_DATA = 2'b00,
    PVIP_TR_FF = 2'b01,
    PVIP_TR_Z1 = 2'b11,
    PVIP_TR_Z2 = 2'b10
  } pvip_tr_e;
  typedef logic [23:0] pvip_pix_t;
endpackage

// [logic/pvip_port.sv]
// Parallel and BT.656 video input port with selectable capture edge
`timescale 1ns/1ns
`include "pvip_params.svh"
module pvip_port
  import pvip_pkg::*;
(
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration, system domain
  input wire logic cfg_fall_edge,
  input wire logic cfg_bt656,
  input wire logic cfg_interlaced,
  input wire logic cfg_portrait,
  input wire logic cfg_vs_load,
  input wire logic [`PVIP_VSDLY_W-1:0] cfg_vs_delay,
  // Status, system domain
  output logic fmt_err,
  output logic frame_evt,
  output logic [`PVIP_VSDLY_W-1:0] vs_delay,
  // Video pins, pixel clock domain
  input wire logic pix_clk,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic active_video_qualifier,
  input wire logic [`PVIP_PIX_W-1:0] pixel_bus,
  // Pixel stream out, pixel clock domain
  output logic pix_valid,
  output pvip_pix_t pix_data,
  output logic pix_luma,
  output logic line_start,
  output logic frame_start,
  output logic field_odd
);

  ////////////////////////////////////////////////////////////////////////////
  // System domain configuration
  logic fmt_err_r, fmt_err_nxt; // Unsupported format seen by software
  logic [`PVIP_VSDLY_W-1:0] vs_delay_r, vs_delay_nxt; // Line delay setting
  logic [2:0] fevt_sync_r; // Frame toggle synchroniser plus edge stage
  logic frame_evt_r, frame_evt_nxt;

  // Next values of system state
  always_comb
  begin
    // Interlaced fields only in landscape
    fmt_err_nxt = cfg_interlaced & cfg_portrait; // RQ6
    vs_delay_nxt = vs_delay_r;
    if (cfg_vs_load)
    begin
      // Field is four bits wide, so fifteen is the ceiling by construction
      vs_delay_nxt = cfg_vs_delay; // RQ9
    end
    frame_evt_nxt = fevt_sync_r[2] ^ fevt_sync_r[1];
  end

  // System registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fmt_err_r <= 1'b0;
      vs_delay_r <= `PVIP_VSDLY_RST; // RQ9
      frame_evt_r <= 1'b0;
      fevt_sync_r <= 3'h0; // Frame toggle crossing starts idle
    end
    else
    begin
      fmt_err_r <= fmt_err_nxt;
      vs_delay_r <= vs_delay_nxt;
      frame_evt_r <= frame_evt_nxt;
      fevt_sync_r <= {fevt_sync_r[1:0], ftog_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the link domain
  // Single-bit settings are quasi-static, so plain two-flop synchronisers suffice;
  // software should not change them mid-frame.
  logic [1:0] rst_l_r; // Reset into pixel domain
  logic [1:0] edge_l_r, bt_l_r, ilace_l_r, err_l_r;
  logic [`PVIP_VSDLY_W-1:0] vsd_l1_r, vsd_l2_r, vsd_l3_r, vsd_use_r; // Delay word crossing
  logic rst_link;

  // Link-side synchronisers
  always_ff @(posedge pix_clk)
  begin
    rst_l_r <= {rst_l_r[0], rst};
    edge_l_r <= {edge_l_r[0], cfg_fall_edge};
    bt_l_r <= {bt_l_r[0], cfg_bt656};
    ilace_l_r <= {ilace_l_r[0], cfg_interlaced};
    err_l_r <= {err_l_r[0], fmt_err_r};
    vsd_l1_r <= vs_delay_r;
    vsd_l2_r <= vsd_l1_r;
    vsd_l3_r <= vsd_l2_r;
    // Word used only once two settled samples agree, so never torn
    if (vsd_l2_r == vsd_l3_r)
    begin
      vsd_use_r <= vsd_l3_r;
    end
  end
  assign rst_link = rst_l_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture on both edges, then one chosen
  // Pins are source-synchronous to pix_clk, so no synchroniser here.
  logic rs_r, rd_r, rv_r, fs_r, fd_r, fv_r;
  pvip_pix_t rp_r, fp_r;
  logic hs_s, de_s, vs_s;
  pvip_pix_t d_s;

  // Rising edge capture
  always_ff @(posedge pix_clk)
  begin
    rs_r <= line_sync;
    rd_r <= active_video_qualifier;
    rv_r <= frame_sync;
    rp_r <= pixel_bus;
  end

  // Falling edge capture
  always_ff @(negedge pix_clk)
  begin
    fs_r <= line_sync;
    fd_r <= active_video_qualifier;
    fv_r <= frame_sync;
    fp_r <= pixel_bus;
  end

  // Edge choice; rising after reset because the setting resets low
  always_comb
  begin
    hs_s = edge_l_r[1] ? fs_r : rs_r; // RQ1
    de_s = edge_l_r[1] ? fd_r : rd_r; // RQ1
    vs_s = edge_l_r[1] ? fv_r : rv_r; // RQ1
    d_s = edge_l_r[1] ? fp_r : rp_r; // RQ1
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state
  pvip_tr_e tr_r, tr_nxt; // Timing reference tracker
  logic hs_q_r, vs_q_r, act_r, act_nxt, luma_r, luma_nxt;
  logic [`PVIP_VSDLY_W-1:0] lcnt_r, lcnt_nxt; // Lines since frame sync
  logic lwait_r, lwait_nxt; // Counting toward frame start
  logic fld_r, fld_nxt, ftog_r, ftog_nxt;
  logic val_nxt, ls_nxt, fst_nxt;
  pvip_pix_t dat_nxt;
  logic [`PVIP_BT_W-1:0] b;

  // Next values of link state
  always_comb
  begin
    b = d_s[`PVIP_BT_W-1:0]; // RQ4
    tr_nxt = tr_r;
    act_nxt = act_r;
    luma_nxt = ~luma_r;
    lcnt_nxt = lcnt_r;
    lwait_nxt = lwait_r;
    fld_nxt = fld_r;
    ftog_nxt = ftog_r;
    val_nxt = 1'b0;
    ls_nxt = 1'b0;
    fst_nxt = 1'b0;
    dat_nxt = d_s;
    if (bt_l_r[1])
    begin
      // Embedded code search: ff 00 00 then status byte
      dat_nxt = {16'h0000, b}; // RQ4
      case (tr_r)
        PVIP_TR_DATA:
          val_nxt = act_r & ~err_l_r[1] & (b != `PVIP_CODE_FF); // RQ3
        PVIP_TR_FF:
          tr_nxt = (b == `PVIP_CODE_00) ? PVIP_TR_Z1 : PVIP_TR_DATA;
        PVIP_TR_Z1:
          tr_nxt = (b == `PVIP_CODE_00) ? PVIP_TR_Z2 : PVIP_TR_DATA;
        PVIP_TR_Z2:
        begin
          // Status byte: start of active video when H and V are low
          tr_nxt = PVIP_TR_DATA;
          act_nxt = ~b[`PVIP_BIT_H] & ~b[`PVIP_BIT_V]; // RQ3
          ls_nxt = ~b[`PVIP_BIT_H] & ~b[`PVIP_BIT_V];
          luma_nxt = 1'b0; // Chroma sample opens every line
          if (b[`PVIP_BIT_F] != fld_r)
          begin
            fld_nxt = b[`PVIP_BIT_F]; // RQ6
            fst_nxt = ~b[`PVIP_BIT_F] | ilace_l_r[1];
            ftog_nxt = ftog_r ^ fst_nxt;
          end
        end
        default:
          tr_nxt = PVIP_TR_DATA;
      endcase
      // Any ff restarts the search, so a repeated ff cannot hide a code
      if (b == `PVIP_CODE_FF)
      begin
        tr_nxt = PVIP_TR_FF; // RQ3
      end
    end
    else
    begin
      tr_nxt = PVIP_TR_DATA;
      act_nxt = 1'b0;
      // Bus words count only under the qualifier
      val_nxt = de_s & ~err_l_r[1]; // RQ10
      ls_nxt = hs_s & ~hs_q_r;
      if (vs_s & ~vs_q_r)
      begin
        // Fields alternate per frame sync when interlaced
        fld_nxt = ilace_l_r[1] & ~fld_r; // RQ6
        lcnt_nxt = '0;
        lwait_nxt = 1'b1;
      end
      else if (ls_nxt & lwait_r)
      begin
        // Frame start after the programmed number of lines
        if (lcnt_r == vsd_use_r)
        begin
          fst_nxt = 1'b1; // RQ9
          lwait_nxt = 1'b0;
          ftog_nxt = ~ftog_r;
        end
        else
        begin
          lcnt_nxt = lcnt_r + 1'b1;
        end
      end
    end
  end

  // Link registers and outputs
  always_ff @(posedge pix_clk)
  begin
    if (rst_link)
    begin
      tr_r <= PVIP_TR_DATA;
      act_r <= 1'b0;
      luma_r <= 1'b0;
      lcnt_r <= '0;
      lwait_r <= 1'b0;
      fld_r <= 1'b0;
      ftog_r <= 1'b0;
      hs_q_r <= 1'b0;
      vs_q_r <= 1'b0;
      pix_valid <= 1'b0;
      pix_data <= '0;
      pix_luma <= 1'b0;
      line_start <= 1'b0;
      frame_start <= 1'b0;
      field_odd <= 1'b0;
    end
    else
    begin
      tr_r <= tr_nxt;
      act_r <= act_nxt;
      luma_r <= luma_nxt;
      lcnt_r <= lcnt_nxt;
      lwait_r <= lwait_nxt;
      fld_r <= fld_nxt;
      ftog_r <= ftog_nxt;
      hs_q_r <= hs_s;
      vs_q_r <= vs_s;
      pix_valid <= val_nxt;
      pix_data <= dat_nxt;
      pix_luma <= bt_l_r[1] & luma_r;
      line_start <= ls_nxt;
      frame_start <= fst_nxt;
      field_odd <= fld_nxt;
    end
  end

  assign fmt_err = fmt_err_r;
  assign frame_evt = frame_evt_r;
  assign vs_delay = vs_delay_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  rise_edge_a: assert property (@(posedge pix_clk) disable iff (rst_link) // RQ1
    !edge_l_r[1] |-> d_s == $past(pixel_bus)) else $error("capture edge not rising");
  qual_gate_a: assert property (@(posedge pix_clk) disable iff (rst_link) // RQ10
    !bt_l_r[1] && !de_s |=> !pix_valid) else $error("valid without qualifier");
  par_data_a: assert property (@(posedge pix_clk) disable iff (rst_link) // RQ10
    !bt_l_r[1] && de_s && !err_l_r[1] |=> pix_valid && pix_data == $past(d_s))
    else $error("parallel word lost");
  low_byte_a: assert property (@(posedge pix_clk) disable iff (rst_link) // RQ4
    bt_l_r[1] |=> pix_data[23:8] == 16'h0000) else $error("upper bus leaked");
  sav_seq_a: assert property (@(posedge pix_clk) disable iff (rst_link) // RQ3
    bt_l_r[1] && tr_r == PVIP_TR_Z2 && b[4] == 1'b0 && b[5] == 1'b0
    |=> line_start ##1 !line_start) else $error("start code missed");
  code_hide_a: assert property (@(posedge pix_clk) disable iff (rst_link) // RQ3
    bt_l_r[1] && tr_r != PVIP_TR_DATA |=> !pix_valid) else $error("code byte passed");
  fmt_block_a: assert property (@(posedge pix_clk) disable iff (rst_link) // RQ6
    err_l_r[1] |=> !pix_valid) else $error("portrait interlace accepted");
  fmt_flag_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
    cfg_interlaced && cfg_portrait |=> fmt_err) else $error("format error not flagged");
  vsd_load_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ9
    cfg_vs_load |=> vs_delay == $past(cfg_vs_delay)) else $error("delay not loaded");
endmodule

// [tb/pvip_port_tb_top.sv]
// Testbench of the parallel video input port
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module pvip_port_tb_top;
  import pvip_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cfg_fall_edge = 1'b0;
  logic cfg_bt656 = 1'b0;
  logic cfg_interlaced = 1'b0;
  logic cfg_portrait = 1'b0;
  logic cfg_vs_load = 1'b0;
  logic [3:0] cfg_vs_delay = 4'h0;
  logic fmt_err, frame_evt, pix_valid, pix_luma, line_start, frame_start, field_odd;
  logic [3:0] vs_delay;
  pvip_pix_t pix_data, pixel_bus;
  logic pix_clk, line_sync, frame_sync, active_video_qualifier;
  logic run = 1'b1;
  int err_total = 0;
  int checks_done = 0;
  int n_ls = 0;
  int n_fs = 0;
  int n_fe = 0;
  logic [24:0] exp_q[$]; // Notes: luma flag and sample
  pvip_pix_t w[$];
  pvip_port pvip_port_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .cfg_fall_edge(cfg_fall_edge),
    .cfg_bt656(cfg_bt656),
    .cfg_interlaced(cfg_interlaced),
    .cfg_portrait(cfg_portrait),
    .cfg_vs_load(cfg_vs_load),
    .cfg_vs_delay(cfg_vs_delay),
    .fmt_err(fmt_err),
    .frame_evt(frame_evt),
    .vs_delay(vs_delay),
    .pix_clk(pix_clk),
    .line_sync(line_sync),
    .frame_sync(frame_sync),
    .active_video_qualifier(active_video_qualifier),
    .pixel_bus(pixel_bus),
    .pix_valid(pix_valid),
    .pix_data(pix_data),
    .pix_luma(pix_luma),
    .line_start(line_start),
    .frame_start(frame_start),
    .field_odd(field_odd)
  );
  pvip_src_model pvip_src_model_i (
    .run(run),
    .fall_mode(cfg_fall_edge),
    .pix_clk(pix_clk),
    .line_sync(line_sync),
    .frame_sync(frame_sync),
    .active_video_qualifier(active_video_qualifier),
    .pixel_bus(pixel_bus)
  );
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  // Monitor: every sample must match the oldest note
  always @(posedge pix_clk)
  begin
    logic [24:0] e;
    if (line_start === 1'b1) n_ls++;
    if (frame_start === 1'b1) n_fs++;
    if (pix_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        err_total++;
        $display("mismatch sample exp none got %h", pix_data);
      end
      else
      begin
        e = exp_q.pop_front();
        if (cfg_bt656) `CHK("byte", e, {pix_luma, pix_data})
        else `CHK("pixel", e, {pix_luma, pix_data})
      end
    end
  end
  always @(posedge clk_sys) if (frame_evt === 1'b1) n_fe++;
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Static settings, then time for the two-flop crossing
  task automatic cfg(input logic fe, bt, il, pt);
    @(posedge clk_sys);
    cfg_fall_edge <= fe;
    cfg_bt656 <= bt;
    cfg_interlaced <= il;
    cfg_portrait <= pt;
    repeat (8) @(posedge pix_clk);
  endtask
  task automatic vs_load(input logic [3:0] v);
    @(posedge clk_sys);
    cfg_vs_delay <= v;
    cfg_vs_load <= 1'b1;
    @(posedge clk_sys);
    cfg_vs_load <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("vs_delay", v, vs_delay)
  endtask
  // Bounded wait until every note is consumed
  task automatic drain;
    for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge pix_clk);
    if (exp_q.size() != 0)
    begin
      err_total++;
      $display("mismatch queue exp 0 got %0d", exp_q.size());
      finish_test();
    end
  endtask
  task automatic send_par(input int n);
    w.delete();
    for (int i = 0; i < n; i++) w.push_back(24'($urandom));
    foreach (w[i]) exp_q.push_back({1'b0, w[i]});
    pvip_src_model_i.par_line(n, w);
  endtask
  // Upper bus bits random: only the low byte may pass
  task automatic send_bt(input int n);
    logic [7:0] b;
    w.delete();
    for (int i = 0; i < n; i++)
    begin
      b = 8'(8'h01 + $urandom % 254);
      w.push_back({16'($urandom), b});
      exp_q.push_back({1'(i % 2), 16'h0000, b});
    end
    pvip_src_model_i.bt_line(w);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(14826));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge pix_clk);
    `CHK("vs_delay rst", 4'h5, vs_delay)
    cfg(1'b0, 1'b0, 1'b1, 1'b1);
    `CHK("fmt_err", 1'b1, fmt_err)
    // Portrait interlace: a qualified line must yield no samples
    w.delete();
    repeat (2) w.push_back(24'($urandom));
    pvip_src_model_i.par_line(2, w);
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    `CHK("fmt_err", 1'b0, fmt_err)
    cfg(1'b0, 1'b0, 1'b0, 1'b0);
    send_par(6);
    drain();
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    send_par(5);
    drain();
    `CHK("lines", 3, n_ls)
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    send_bt(6);
    drain();
    `CHK("bt lines", 4, n_ls)
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    `CHK("field", 1'b0, field_odd)
    vs_load(4'hf);
    vs_load(4'h1);
    pvip_src_model_i.set_fs(1'b1);
    send_par(2);
    pvip_src_model_i.set_fs(1'b0);
    repeat (2) send_par(2);
    drain();
    repeat (10) @(posedge clk_sys);
    `CHK("frames", 1, n_fs)
    `CHK("frame events", 1, n_fe)
    `CHK("field", 1'b1, field_odd)
    finish_test();
  end
endmodule

// [tb/pvip_src_model.sv]
// Video source model driving the port's pins
`timescale 1ns/1ns
module pvip_src_model (
  // Clock gate and edge choice
  input wire logic run,
  input wire logic fall_mode,
  // Pins toward the port
  output logic pix_clk,
  output logic line_sync,
  output logic frame_sync,
  output logic active_video_qualifier,
  output logic [23:0] pixel_bus
);
  // Line period in pixel clocks: 8 MHz over 471 stays under the 17 kHz limit
  localparam int LINE_CLKS = 471;
  initial
  begin
    pix_clk = 1'b0;
    line_sync = 1'b0;
    frame_sync = 1'b0;
    active_video_qualifier = 1'b0;
    pixel_bus = 24'h000000;
  end
  // Link clock, 125 ns, held low when stopped
  always
  begin
    #63;
    pix_clk = run;
    #62;
    pix_clk = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Pins change on the other edge, so setup and hold both hold
  task automatic tick(input logic ls, input logic q, input logic [23:0] d);
    if (fall_mode) @(posedge pix_clk); else @(negedge pix_clk);
    line_sync = ls;
    active_video_qualifier = q;
    pixel_bus = d;
  endtask
  // Frame sync level, changed like the other pins
  task automatic set_fs(input logic v);
    if (fall_mode) @(posedge pix_clk); else @(negedge pix_clk);
    frame_sync = v;
  endtask
  // Parallel line; bus toggles while unqualified so stale data shows
  task automatic par_line(input int n, input logic [23:0] w[$]);
    repeat (4) tick(1'b1, 1'b0, ~pixel_bus);
    repeat (4) tick(1'b0, 1'b0, ~pixel_bus);
    for (int i = 0; i < n; i++) tick(1'b0, 1'b1, w[i]);
    repeat (8) tick(1'b0, 1'b0, ~pixel_bus);
    repeat (LINE_CLKS - 16 - n) tick(1'b0, 1'b0, ~pixel_bus);
  endtask
  // BT.656 line: start code, bytes, end code with H set
  task automatic bt_line(input logic [23:0] w[$]);
    logic [7:0] c[8] = '{8'hff, 8'h00, 8'h00, 8'h80, 8'hff, 8'h00, 8'h00, 8'h90};
    for (int i = 0; i < 4; i++) tick(1'b0, 1'b0, {16'hffff, c[i]});
    foreach (w[i]) tick(1'b0, 1'b0, w[i]);
    for (int i = 4; i < 8; i++) tick(1'b0, 1'b0, {16'h0000, c[i]});
  endtask
endmodule
